// ---- common/gssr_pkg.sv ----
// constants for the bus status and service request block
`default_nettype none
package gssr_pkg;
    // apb byte offsets
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_ESR = 8'h08;
    localparam logic [7:0] REG_ESE = 8'h0c;
    localparam logic [7:0] REG_SRE = 8'h10;
    localparam logic [7:0] REG_STB = 8'h14;
    localparam logic [7:0] REG_OPCND = 8'h18;
    localparam logic [7:0] REG_OPEV = 8'h1c;
    localparam logic [7:0] REG_OPEN = 8'h20;
    localparam logic [7:0] REG_CMD = 8'h24;
    localparam int CMD_CLS = 0;
    // bus address
    localparam logic [4:0] ADDR_DEF = 5'h0c;
    localparam logic [4:0] ADDR_MIN = 5'h01;
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    localparam logic [4:0] ADDR_UN = 5'h1f;
    // standard event bits
    localparam int ESR_PON = 7;
    localparam int ESR_CME = 5;
    localparam int ESR_EXE = 4;
    localparam int ESR_QYE = 2;
    localparam int ESR_OPC = 0;
    localparam logic [7:0] ESR_RST = 8'h80;
    // status byte bits
    localparam int STB_OSB = 7;
    localparam int STB_MSS = 6;
    localparam int STB_ESB = 5;
    // multiline commands, low seven bits
    localparam logic [6:0] C_GTL = 7'h01;
    localparam logic [6:0] C_SDC = 7'h04;
    localparam logic [6:0] C_LLO = 7'h11;
    localparam logic [6:0] C_DCL = 7'h14;
    localparam logic [6:0] C_SPE = 7'h18;
    localparam logic [6:0] C_SPD = 7'h19;
    localparam logic [1:0] G_LISTEN = 2'h1;
    localparam logic [1:0] G_TALK = 2'h2;
    // characters
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_QM = 8'h3f;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] MAX_LEN = 8'hff;
    // common headers
    localparam logic [23:0] H_CLS = 24'h434c53;
    localparam logic [23:0] H_ESE = 24'h455345;
    localparam logic [23:0] H_ESR = 24'h455352;
    localparam logic [23:0] H_SRE = 24'h535245;
    localparam logic [23:0] H_STB = 24'h535442;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } gssr_tx_t;
endpackage
`default_nettype wire

// ---- rtl/gssr_top.sv ----
// bus control decode, message framing and status reporting
// Behaviour
// - ren asserted enters remote, keypad disabled
// - ifc aborts transfer and unaddresses device
// - srq is the only line driven
// - bytes under atn are commands
// - llo locks front panel until release
// - dcl clears interface activity to idle
// - sdc acts only when listen addressed
// - addressed gtl returns to local
// - serial poll returns status byte
// - response only when talk addressed
// - only the latest query answered
// - condition register live, read only
// - event bits latch, repeats ignored
// - standard events cleared by query or clear, operation events by clear only
// - summary is any enabled event
// - status byte mirrors summaries, non-latching
// - enabled summary sets rqs and srq
// - service request enable read/write
// - register answers in ascii decimal
// - standard event bit positions fixed
// - address 1 to 30, default 12
`default_nettype none
module gssr_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic atn_n,
    input wire logic ren_n,
    input wire logic ifc_n,
    input wire logic dav_n,
    input wire logic [7:0] dio_n,
    input wire logic srq_n_in,
    output logic srq_n_out,
    output logic srq_oe_n,
    output logic [7:0] resp_data,
    output logic resp_valid,
    output logic resp_last,
    input wire logic resp_ready,
    input wire logic ev_exe,
    input wire logic ev_opc,
    input wire logic [7:0] op_cond,
    output logic remote,
    output logic lockout,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        logic [3:0] pin1;
        logic [3:0] pin2;
        logic [7:0] dio1;
        logic [7:0] dio2;
        logic srq1;
        logic srq2;
        logic dav3;
        logic ren3;
        logic remote;
        logic lockout;
        logic lad;
        logic tad;
        logic spm;
        logic pdone;
        logic [4:0] addr;
        logic [7:0] esr;
        logic [7:0] ese;
        logic [7:0] sre;
        logic [7:0] ope;
        logic [7:0] open;
        logic [7:0] opcp;
        logic [7:0] cnt;
        logic [23:0] hdr;
        logic star;
        logic isq;
        logic inpar;
        logic perr;
        logic uerr;
        logic [7:0] pval;
        logic qpend;
        logic [7:0] qval;
        gssr_pkg::gssr_tx_t tx;
        logic [2:0] tidx;
        logic [7:0] rdat;
        logic rval;
        logic rlast;
        logic pready;
        logic pslverr;
        logic [7:0] prd;
    } gssr_st_t;

    gssr_st_t q;
    gssr_st_t n;
    logic atn, ren, ifc, take, cmd_stb, dat_stb;
    logic clr_ev, esr_rd, poll_go, abort, mss;
    logic [7:0] b, stb, sum, esr_set;
    logic [11:0] acc10;
    logic [7:0] dg_h, dg_t, dg_o;
    logic [2:0] tstart;

    always_comb begin
        n = q;
        // pins are active low; two flops before use
        n.pin1 = {~atn_n, ~ren_n, ~ifc_n, ~dav_n};
        n.pin2 = q.pin1;
        n.dio1 = ~dio_n;
        n.dio2 = q.dio1;
        n.srq1 = ~srq_n_in;
        n.srq2 = q.srq1;
        n.dav3 = q.pin2[0];
        n.ren3 = q.pin2[2];
        atn = q.pin2[3];
        ren = q.pin2[2];
        ifc = q.pin2[1];
        b = q.dio2;
        take = q.pin2[0] & ~q.dav3;
        cmd_stb = take & atn;
        dat_stb = take & ~atn & q.lad;
        clr_ev = 1'b0;
        esr_rd = 1'b0;
        abort = 1'b0;
        esr_set = 8'h00;
        acc10 = ({4'h0, q.pval} * 12'h00a) + {8'h00, b[3:0]};

        // status byte and service request
        sum = 8'h00;
        sum[gssr_pkg::STB_OSB] = |(q.ope & q.open);
        sum[gssr_pkg::STB_ESB] = |(q.esr & q.ese);
        mss = |(sum & q.sre);
        stb = sum;
        stb[gssr_pkg::STB_MSS] = mss;

        // remote and lockout
        if (!ren) begin
            n.remote = 1'b0;
            n.lockout = 1'b0;
        end else if (!q.ren3) begin
            n.remote = 1'b1;
        end

        // multiline commands
        if (cmd_stb) begin
            if (b[6:5] == gssr_pkg::G_LISTEN) begin
                if (b[4:0] == gssr_pkg::ADDR_UN) begin
                    n.lad = 1'b0;
                end else if (b[4:0] == q.addr) begin
                    n.lad = 1'b1;
                    n.tad = 1'b0;
                    if (ren) begin
                        n.remote = 1'b1;
                    end
                end
            end else if (b[6:5] == gssr_pkg::G_TALK) begin
                if (b[4:0] == q.addr) begin
                    n.tad = 1'b1;
                    n.lad = 1'b0;
                end else begin
                    n.tad = 1'b0;
                end
                n.pdone = 1'b0;
            end else if (b[6:0] == gssr_pkg::C_LLO) begin
                n.lockout = ren;
            end else if (b[6:0] == gssr_pkg::C_DCL) begin
                abort = 1'b1;
            end else if (b[6:0] == gssr_pkg::C_SDC) begin
                abort = q.lad;
            end else if (b[6:0] == gssr_pkg::C_GTL) begin
                if (q.lad) begin
                    n.remote = 1'b0;
                end
            end else if (b[6:0] == gssr_pkg::C_SPE) begin
                n.spm = 1'b1;
                n.pdone = 1'b0;
            end else if (b[6:0] == gssr_pkg::C_SPD) begin
                n.spm = 1'b0;
            end
        end

        // message framing of listened data
        if (dat_stb) begin
            if (q.cnt == gssr_pkg::MAX_LEN) begin
                n.uerr = 1'b1;
            end else begin
                n.cnt = q.cnt + 8'h01;
            end
            if (b == gssr_pkg::CH_LF || b == gssr_pkg::CH_SEMI) begin
                if (q.star) begin
                    if (q.uerr) begin
                        esr_set[gssr_pkg::ESR_CME] = 1'b1;
                    end else if (q.hdr == gssr_pkg::H_CLS && !q.isq) begin
                        clr_ev = 1'b1;
                    end else if (q.hdr == gssr_pkg::H_ESE && q.isq) begin
                        n.qval = q.ese;
                    end else if (q.hdr == gssr_pkg::H_SRE && q.isq) begin
                        n.qval = q.sre;
                    end else if (q.hdr == gssr_pkg::H_STB && q.isq) begin
                        n.qval = stb;
                    end else if (q.hdr == gssr_pkg::H_ESR && q.isq) begin
                        n.qval = q.esr;
                        esr_rd = 1'b1;
                    end else if (q.hdr == gssr_pkg::H_ESE && q.inpar && !q.perr) begin
                        n.ese = q.pval;
                    end else if (q.hdr == gssr_pkg::H_SRE && q.inpar && !q.perr) begin
                        n.sre = q.pval;
                    end else begin
                        esr_set[gssr_pkg::ESR_CME] = 1'b1;
                    end
                    if (q.isq && !q.uerr) begin
                        // latest query replaces any unanswered one
                        n.qpend = 1'b1;
                        esr_set[gssr_pkg::ESR_QYE] = q.qpend;
                    end
                end else if (q.uerr) begin
                    esr_set[gssr_pkg::ESR_CME] = 1'b1;
                end
                n.hdr = 24'h000000;
                n.star = 1'b0;
                n.isq = 1'b0;
                n.inpar = 1'b0;
                n.perr = 1'b0;
                n.uerr = 1'b0;
                n.pval = 8'h00;
                if (b == gssr_pkg::CH_LF) begin
                    n.cnt = 8'h00;
                end
            end else if (b == gssr_pkg::CH_CR) begin
                n.cnt = n.cnt;
            end else if (q.inpar) begin
                if (b >= gssr_pkg::CH_0 && b <= 8'h39) begin
                    n.pval = acc10[7:0];
                    n.perr = q.perr | (acc10 > 12'h0ff);
                end else if (b != gssr_pkg::CH_SP) begin
                    n.perr = 1'b1;
                end
            end else if (b == gssr_pkg::CH_SP) begin
                n.inpar = 1'b1;
            end else if (b == gssr_pkg::CH_QM) begin
                n.isq = 1'b1;
            end else if (b == gssr_pkg::CH_STAR) begin
                if (q.hdr == 24'h000000 && !q.star) begin
                    n.star = 1'b1;
                end else begin
                    n.uerr = 1'b1;
                end
            end else begin
                n.hdr = {q.hdr[15:0], b};
            end
        end

        // interface clear and device clear
        if (ifc) begin
            n.lad = 1'b0;
            n.tad = 1'b0;
            n.spm = 1'b0;
            abort = 1'b1;
        end
        if (abort) begin
            n.cnt = 8'h00;
            n.hdr = 24'h000000;
            n.star = 1'b0;
            n.isq = 1'b0;
            n.inpar = 1'b0;
            n.perr = 1'b0;
            n.uerr = 1'b0;
            n.pval = 8'h00;
            n.qpend = 1'b0;
        end

        // response path
        dg_h = q.qval / 8'h64;
        dg_t = (q.qval / 8'h0a) % 8'h0a;
        dg_o = q.qval % 8'h0a;
        tstart = (q.qval >= 8'h64) ? 3'h0 : ((q.qval >= 8'h0a) ? 3'h1 : 3'h2);
        poll_go = q.spm && q.tad && n.tad && !q.pdone && !q.rval && !abort
            && q.tx == gssr_pkg::TX_IDLE;
        if (q.rval && resp_ready) begin
            n.rval = 1'b0;
        end
        if (poll_go) begin
            n.rdat = stb;
            n.rlast = 1'b1;
            n.rval = 1'b1;
            n.pdone = 1'b1;
        end else if (q.tx == gssr_pkg::TX_IDLE) begin
            if (q.tad && !q.spm && q.qpend && !q.rval) begin
                n.tx = gssr_pkg::TX_SEND;
                n.tidx = tstart;
            end
        end else if (!q.rval || resp_ready) begin
            n.rval = 1'b1;
            n.rlast = (q.tidx == 3'h4);
            n.tidx = q.tidx + 3'h1;
            if (q.tidx == 3'h0) begin
                n.rdat = gssr_pkg::CH_0 + dg_h;
            end else if (q.tidx == 3'h1) begin
                n.rdat = gssr_pkg::CH_0 + dg_t;
            end else if (q.tidx == 3'h2) begin
                n.rdat = gssr_pkg::CH_0 + dg_o;
            end else if (q.tidx == 3'h3) begin
                n.rdat = gssr_pkg::CH_CR;
            end else begin
                n.rdat = gssr_pkg::CH_LF;
                n.tx = gssr_pkg::TX_IDLE;
                n.qpend = 1'b0;
            end
        end
        // talk address lost at this edge drops the answer too
        if (abort || !q.tad || !n.tad) begin
            n.tx = gssr_pkg::TX_IDLE;
            n.rval = 1'b0;
        end

        // apb slave, one wait state
        if (psel && penable && !q.pready) begin
            n.pready = 1'b1;
            n.pslverr = 1'b0;
            n.prd = 8'h00;
            if (paddr == gssr_pkg::REG_CFG) begin
                n.prd = {3'h0, q.addr};
            end else if (paddr == gssr_pkg::REG_STAT) begin
                n.prd = {2'h0, q.srq2, q.spm, q.tad, q.lad, q.lockout, q.remote};
            end else if (paddr == gssr_pkg::REG_ESR) begin
                n.prd = q.esr;
            end else if (paddr == gssr_pkg::REG_ESE) begin
                n.prd = q.ese;
            end else if (paddr == gssr_pkg::REG_SRE) begin
                n.prd = q.sre;
            end else if (paddr == gssr_pkg::REG_STB) begin
                n.prd = stb;
            end else if (paddr == gssr_pkg::REG_OPCND) begin
                n.prd = op_cond;
            end else if (paddr == gssr_pkg::REG_OPEV) begin
                n.prd = q.ope;
            end else if (paddr == gssr_pkg::REG_OPEN) begin
                n.prd = q.open;
            end else if (paddr != gssr_pkg::REG_CMD) begin
                n.pslverr = 1'b1;
            end
        end else begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
        end
        if (psel && penable && q.pready && pwrite) begin
            if (paddr == gssr_pkg::REG_CFG) begin
                if (pwdata[4:0] >= gssr_pkg::ADDR_MIN && pwdata[4:0] <= gssr_pkg::ADDR_MAX) begin
                    n.addr = pwdata[4:0];
                end
            end else if (paddr == gssr_pkg::REG_ESE) begin
                n.ese = pwdata[7:0];
            end else if (paddr == gssr_pkg::REG_SRE) begin
                n.sre = pwdata[7:0];
            end else if (paddr == gssr_pkg::REG_OPEN) begin
                n.open = pwdata[7:0];
            end else if (paddr == gssr_pkg::REG_CMD) begin
                clr_ev = pwdata[gssr_pkg::CMD_CLS];
            end
        end

        // event latching; a new event wins over a clear
        esr_set[gssr_pkg::ESR_EXE] = ev_exe;
        esr_set[gssr_pkg::ESR_OPC] = ev_opc;
        n.opcp = op_cond;
        n.esr = ((clr_ev || esr_rd) ? 8'h00 : q.esr) | esr_set;
        n.ope = (clr_ev ? 8'h00 : q.ope) | (op_cond & ~q.opcp);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.esr <= gssr_pkg::ESR_RST;
            q.addr <= gssr_pkg::ADDR_DEF;
            q.tx <= gssr_pkg::TX_IDLE;
        end else begin
            q <= n;
        end
    end

    assign srq_n_out = 1'b0;
    assign srq_oe_n = ~mss;
    assign resp_data = q.rdat;
    assign resp_valid = q.rval;
    assign resp_last = q.rlast;
    assign remote = q.remote;
    assign lockout = q.lockout;
    assign prdata = {24'h000000, q.prd};
    assign pready = q.pready;
    assign pslverr = q.pslverr;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_llo;
        cmd_stb && b[6:0] == gssr_pkg::C_LLO && ren;
    endsequence
    sequence s_gtl;
        cmd_stb && b[6:0] == gssr_pkg::C_GTL && q.lad && !(ren && !q.ren3);
    endsequence
    sequence s_dcl;
        cmd_stb && b[6:0] == gssr_pkg::C_DCL;
    endsequence

    property p_ren;
        $rose(q.pin2[2]) |=> q.remote;
    endproperty
    a_ren: assert property (p_ren) else $error("remote not entered");
    property p_ifc;
        ifc |=> !q.tad && !q.lad && !resp_valid;
    endproperty
    a_ifc: assert property (p_ifc) else $error("ifc did not abort");
    property p_srq;
        (sum[gssr_pkg::STB_ESB] && q.sre[gssr_pkg::STB_ESB]) |-> !srq_oe_n;
    endproperty
    a_srq: assert property (p_srq) else $error("srq not driven");
    property p_atn;
        (cmd_stb && !ifc && b[6:0] != gssr_pkg::C_DCL && b[6:0] != gssr_pkg::C_SDC)
            |=> q.cnt == $past(q.cnt);
    endproperty
    a_atn: assert property (p_atn) else $error("command byte counted as data");
    property p_llo;
        s_llo |=> q.lockout;
    endproperty
    a_llo: assert property (p_llo) else $error("lockout not set");
    property p_dcl;
        s_dcl |=> !q.qpend && q.tx == gssr_pkg::TX_IDLE && q.cnt == 8'h00;
    endproperty
    a_dcl: assert property (p_dcl) else $error("device clear incomplete");
    property p_gtl;
        s_gtl |=> !q.remote;
    endproperty
    a_gtl: assert property (p_gtl) else $error("go to local ignored");
    property p_poll;
        poll_go |=> resp_valid && resp_last && resp_data == $past(stb);
    endproperty
    a_poll: assert property (p_poll) else $error("poll byte wrong");
    property p_talk;
        resp_valid |-> q.tad;
    endproperty
    a_talk: assert property (p_talk) else $error("answer while not talker");
    property p_latch;
        (q.esr[gssr_pkg::ESR_CME] && !clr_ev && !esr_rd) |=> q.esr[gssr_pkg::ESR_CME];
    endproperty
    a_latch: assert property (p_latch) else $error("event bit lost");
    property p_stb;
        stb[gssr_pkg::STB_ESB] == |(q.esr & q.ese);
    endproperty
    a_stb: assert property (p_stb) else $error("summary mismatch");
    property p_addr;
        q.addr >= gssr_pkg::ADDR_MIN && q.addr <= gssr_pkg::ADDR_MAX;
    endproperty
    a_addr: assert property (p_addr) else $error("address out of range");
endmodule
`default_nettype wire

// ---- tb/gssr_ctl.sv ----
// bus controller model driving the instrument bus pins
`default_nettype none
module gssr_ctl (
    input wire logic mclk,
    output logic atn_n,
    output logic ren_n,
    output logic ifc_n,
    output logic dav_n,
    output logic [7:0] dio_n,
    input wire logic [7:0] resp_data,
    input wire logic resp_valid,
    output logic resp_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow;
    logic [7:0] rx_q[$];
    initial begin
        atn_n = 1'b1;
        ren_n = 1'b1;
        ifc_n = 1'b1;
        dav_n = 1'b1;
        dio_n = 8'hff;
        slow = 1'b0;
        resp_ready = 1'b0;
    end
    // slow mode takes a byte every other cycle
    always @(posedge mclk) begin
        resp_ready <= slow ? ~resp_ready : 1'b1;
        if (resp_valid && resp_ready) begin
            rx_q.push_back(resp_data);
        end
    end
    // one byte, command when atn is set
    task automatic put(input logic atn, input logic [7:0] b);
        @(posedge mclk);
        atn_n <= ~atn;
        dio_n <= ~b;
        repeat (2) @(posedge mclk);
        dav_n <= 1'b0;
        repeat (6) @(posedge mclk);
        dav_n <= 1'b1;
        repeat (2) @(posedge mclk);
        dio_n <= 8'hff;
        repeat (4) @(posedge mclk);
    endtask
    // listen address, then characters as data
    task automatic send(input logic [7:0] mla, input string s);
        put(1'b1, mla);
        foreach (s[i]) begin
            put(1'b0, s[i]);
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/gssr_top_tb.sv ----
// self-checking bench for the bus status and service request block
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module gssr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MLA = {1'b0, gssr_pkg::G_LISTEN, gssr_pkg::ADDR_DEF};
    localparam logic [7:0] MTA = {1'b0, gssr_pkg::G_TALK, gssr_pkg::ADDR_DEF};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic atn_n, ren_n, ifc_n, dav_n, srq_n_in, srq_n_out, srq_oe_n;
    logic resp_valid, resp_last, resp_ready, remote, lockout, pready, pslverr;
    logic [7:0] dio_n, resp_data;
    logic [7:0] op_cond = 8'h00;
    logic [7:0] paddr = 8'h00;
    logic ev_exe = 1'b0;
    logic ev_opc = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic err;
    int error_cnt = 0;
    int n_compared = 0;
    int n_last = 0;
    always @(posedge mclk) begin
        if (resp_valid && resp_ready && resp_last) begin
            n_last <= n_last + 1;
        end
    end
    always #12.5 mclk = ~mclk;
    assign srq_n_in = srq_oe_n ? 1'b1 : srq_n_out;
    gssr_top gssr_top_i (.mclk(mclk), .rst(rst), .atn_n(atn_n), .ren_n(ren_n), .ifc_n(ifc_n),
        .dav_n(dav_n), .dio_n(dio_n), .srq_n_in(srq_n_in), .srq_n_out(srq_n_out),
        .srq_oe_n(srq_oe_n), .resp_data(resp_data), .resp_valid(resp_valid),
        .resp_last(resp_last), .resp_ready(resp_ready), .ev_exe(ev_exe), .ev_opc(ev_opc),
        .op_cond(op_cond), .remote(remote), .lockout(lockout), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    gssr_ctl gssr_ctl_i (.mclk(mclk), .atn_n(atn_n), .ren_n(ren_n), .ifc_n(ifc_n),
        .dav_n(dav_n), .dio_n(dio_n), .resp_data(resp_data), .resp_valid(resp_valid),
        .resp_ready(resp_ready));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask
    // address as talker, collect the answer, unaddress
    task automatic talk(input string ex);
        int k;
        int l0;
        k = 0;
        l0 = n_last;
        gssr_ctl_i.put(1'b1, MTA);
        while (gssr_ctl_i.rx_q.size() < ex.len() && k < 300) begin
            @(posedge mclk);
            k++;
        end
        `CHK("resp_len", ex.len(), gssr_ctl_i.rx_q.size())
        foreach (ex[i]) begin
            `CHK("resp", ex[i], gssr_ctl_i.rx_q[i])
        end
        gssr_ctl_i.put(1'b1, 8'h5f);
        `CHK("resp_last", 1, n_last - l0)
    endtask
    task automatic t_regs;
        rdchk("esr", gssr_pkg::REG_ESR, 32'h80);
        rdchk("cfg", gssr_pkg::REG_CFG, 32'h0c);
        apb(1'b1, gssr_pkg::REG_CFG, 32'h1f);
        rdchk("cfg", gssr_pkg::REG_CFG, 32'h0c);
        apb(1'b1, gssr_pkg::REG_SRE, 32'h20);
        rdchk("sre", gssr_pkg::REG_SRE, 32'h20);
        apb(1'b0, 8'h3c, 32'h0);
        `CHK("slverr", 1'b1, err)
        op_cond <= 8'h5a;
        rdchk("opcnd", gssr_pkg::REG_OPCND, 32'h5a);
        op_cond <= 8'h00;
        rdchk("opcnd", gssr_pkg::REG_OPCND, 32'h00);
        gssr_ctl_i.send(MLA, "*SRE 48\n");
        rdchk("sre", gssr_pkg::REG_SRE, 32'h30);
        $display("test regs done");
    endtask
    task automatic t_remote;
        gssr_ctl_i.ren_n <= 1'b0;
        repeat (10) @(posedge mclk);
        `CHK("remote", 1'b1, remote)
        gssr_ctl_i.put(1'b1, {1'b0, gssr_pkg::C_LLO});
        `CHK("lockout", 1'b1, lockout)
        gssr_ctl_i.put(1'b1, MLA);
        gssr_ctl_i.put(1'b1, {1'b0, gssr_pkg::C_GTL});
        `CHK("remote", 1'b0, remote)
        gssr_ctl_i.ren_n <= 1'b1;
        repeat (10) @(posedge mclk);
        `CHK("lockout", 1'b0, lockout)
        $display("test remote done");
    endtask
    task automatic t_srq;
        apb(1'b1, gssr_pkg::REG_ESE, 32'h80);
        rdchk("stb", gssr_pkg::REG_STB, 32'h60);
        `CHK("srq_oe_n", 1'b0, srq_oe_n)
        rdchk("stat", gssr_pkg::REG_STAT, 32'h24);
        gssr_ctl_i.put(1'b1, {1'b0, gssr_pkg::C_SPE});
        gssr_ctl_i.rx_q.delete();
        gssr_ctl_i.put(1'b1, MTA);
        `CHK("poll", 8'h60, gssr_ctl_i.rx_q[0])
        gssr_ctl_i.put(1'b1, {1'b0, gssr_pkg::C_SPD});
        gssr_ctl_i.put(1'b1, 8'h5f);
        gssr_ctl_i.send(MLA, "*CLS\n");
        `CHK("srq_oe_n", 1'b1, srq_oe_n)
        rdchk("esr", gssr_pkg::REG_ESR, 32'h00);
        $display("test srq done");
    endtask
    task automatic t_events;
        repeat (2) begin
            @(posedge mclk);
            ev_exe <= 1'b1;
            @(posedge mclk);
            ev_exe <= 1'b0;
        end
        ev_opc <= 1'b1;
        @(posedge mclk);
        ev_opc <= 1'b0;
        rdchk("esr", gssr_pkg::REG_ESR, 32'h11);
        gssr_ctl_i.rx_q.delete();
        gssr_ctl_i.send(MLA, "*ESR?\n");
        repeat (20) @(posedge mclk);
        `CHK("early", 0, gssr_ctl_i.rx_q.size())
        talk("17\r\n");
        rdchk("esr", gssr_pkg::REG_ESR, 32'h00);
        $display("test events done");
    endtask
    task automatic t_latest;
        gssr_ctl_i.slow = 1'b1;
        gssr_ctl_i.rx_q.delete();
        gssr_ctl_i.send(MLA, "*SRE?\n");
        gssr_ctl_i.send(MLA, "*ESE?\n");
        talk("128\r\n");
        rdchk("esr", gssr_pkg::REG_ESR, 32'h04);
        gssr_ctl_i.slow = 1'b0;
        $display("test latest done");
    endtask
    task automatic t_clear;
        gssr_ctl_i.send(MLA, "*STB?\n");
        gssr_ctl_i.put(1'b1, {1'b0, gssr_pkg::C_DCL});
        gssr_ctl_i.rx_q.delete();
        gssr_ctl_i.put(1'b1, MTA);
        repeat (30) @(posedge mclk);
        `CHK("dcl", 0, gssr_ctl_i.rx_q.size())
        gssr_ctl_i.put(1'b1, 8'h5f);
        gssr_ctl_i.send(MLA, "*STB?\n");
        gssr_ctl_i.put(1'b1, 8'h3f);
        gssr_ctl_i.put(1'b1, {1'b0, gssr_pkg::C_SDC});
        talk("0\r\n");
        gssr_ctl_i.send(MLA, "*STB?\n");
        gssr_ctl_i.put(1'b1, {1'b0, gssr_pkg::C_SDC});
        gssr_ctl_i.rx_q.delete();
        gssr_ctl_i.put(1'b1, MTA);
        repeat (30) @(posedge mclk);
        `CHK("sdc", 0, gssr_ctl_i.rx_q.size())
        gssr_ctl_i.put(1'b1, 8'h5f);
        $display("test clear done");
    endtask
    task automatic t_ifc;
        gssr_ctl_i.send(MLA, "*SRE?\n");
        gssr_ctl_i.ifc_n <= 1'b0;
        repeat (6) @(posedge mclk);
        gssr_ctl_i.ifc_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rdchk("stat", gssr_pkg::REG_STAT, 32'h00);
        gssr_ctl_i.rx_q.delete();
        gssr_ctl_i.put(1'b1, MTA);
        repeat (30) @(posedge mclk);
        `CHK("ifc", 0, gssr_ctl_i.rx_q.size())
        gssr_ctl_i.put(1'b1, 8'h5f);
        $display("test ifc done");
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_regs();
        t_remote();
        t_srq();
        t_events();
        t_latest();
        t_clear();
        t_ifc();
        tally_and_finish();
    end
    initial begin
        #300us;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
